/* File: rtl/feg_pkg.sv */
`default_nettype none

package feg_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [11:0] FEG_OFF_CONTROL    = 12'h038;
    localparam logic [11:0] FEG_OFF_MSG_DATA   = 12'h03c;
    localparam logic [11:0] FEG_OFF_MSG_ADDR   = 12'h040;
    localparam logic [11:0] FEG_OFF_IRQ_STATUS = 12'h050;
    localparam logic [11:0] FEG_OFF_IRQ_MASK   = 12'h054;

    // Field positions in the control, data and address registers.
    localparam int unsigned FEG_BIT_MASK       = 31;
    localparam int unsigned FEG_BIT_PENDING    = 30;
    localparam int unsigned FEG_DATA_LOW_W     = 16;
    localparam int unsigned FEG_ADDR_LSB       = 2;

    // Reset values.
    localparam logic        FEG_RST_MASK       = 1'b1;
    localparam logic        FEG_RST_PENDING    = 1'b0;
    localparam logic [31:0] FEG_RST_WORD       = 32'h0000_0000;

    // Interrupt status bits of the local sticky status register.
    localparam int unsigned FEG_IRQ_W          = 3;
    localparam int unsigned FEG_EV_CONDITION   = 0;
    localparam int unsigned FEG_EV_SENT        = 1;
    localparam int unsigned FEG_EV_SW_SERVICED = 2;
    localparam logic [2:0]  FEG_RST_IRQ        = 3'h0;

    // AXI response codes.
    localparam logic [1:0]  FEG_RESP_OKAY      = 2'h0;
    localparam logic [1:0]  FEG_RESP_SLVERR    = 2'h2;

    // Register selection produced by the address decoder.
    typedef enum logic [2:0] {
        FEG_SEL_NONE,
        FEG_SEL_CONTROL,
        FEG_SEL_MSG_DATA,
        FEG_SEL_MSG_ADDR,
        FEG_SEL_IRQ_STATUS,
        FEG_SEL_IRQ_MASK
    } feg_sel_type;

    // Fault status flags seen from the fault status register.
    typedef struct packed {
        logic completion_timeout_flag;
        logic completion_error_flag;
        logic queue_error_flag;
        logic advanced_fault_flag;
        logic advanced_overflow_flag;
        logic fault_overflow_flag;
    } feg_status_type;

    // Interrupt message memory write.
    typedef struct packed {
        logic [31:0] message_address;
        logic [31:0] message_data;
    } feg_msg_type;

endpackage : feg_pkg

`default_nettype wire

/* File: rtl/feg_fault_event_gen.sv */
// Added by the designer: the AXI4-Lite interface to the registers.
`default_nettype none

module feg_fault_event_gen #(
    parameter int unsigned ADDR_W      = 12, // AXI address width.
    parameter int unsigned NUM_RECORDS = 8,  // Number of fault recording registers.
    parameter bit          EXT_DATA    = 1'b0 // One when 32-bit message data is supported.
) (
    input  wire logic                  aclk,            // System clock.
    input  wire logic                  aresetn,         // Synchronous reset, active low.
    input  wire logic                  ce,              // Clock enable, freezes all state when low.
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,    // Write address.
    input  wire logic                  s_axi_awvalid,   // Write address valid.
    output var  logic                  s_axi_awready,   // Write address ready.
    input  wire logic [31:0]           s_axi_wdata,     // Write data.
    input  wire logic [3:0]            s_axi_wstrb,     // Write byte strobes.
    input  wire logic                  s_axi_wvalid,    // Write data valid.
    output var  logic                  s_axi_wready,    // Write data ready.
    output var  logic [1:0]            s_axi_bresp,     // Write response.
    output var  logic                  s_axi_bvalid,    // Write response valid.
    input  wire logic                  s_axi_bready,    // Write response ready.
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,    // Read address.
    input  wire logic                  s_axi_arvalid,   // Read address valid.
    output var  logic                  s_axi_arready,   // Read address ready.
    output var  logic [31:0]           s_axi_rdata,     // Read data.
    output var  logic [1:0]            s_axi_rresp,     // Read response.
    output var  logic                  s_axi_rvalid,    // Read data valid.
    input  wire logic                  s_axi_rready,    // Read data ready.
    input  wire logic [NUM_RECORDS-1:0] fault_present, // Fault bit of each recording register.
    input  wire logic                  advanced_mode,   // High when advanced fault logging is active.
    input  wire feg_pkg::feg_status_type status_flags,  // Other fault status flags.
    output var  feg_pkg::feg_msg_type  msg_out,         // Message address and data.
    output var  logic                  msg_valid,       // Message write valid.
    input  wire logic                  msg_ready,       // Message write accepted.
    output var  logic                  irq              // Level interrupt, unmasked status set.
);
    import feg_pkg::*;

    // Refuse configurations the decoder and the flag logic cannot serve; the decoder reads 12 address bits.
    if (ADDR_W < 12 || ADDR_W > 32 || NUM_RECORDS < 1) begin : gen_bad_params
        $error("feg_fault_event_gen: unsupported parameter values");
    end

    // Maps a byte address onto a register; only aligned words decode.
    function automatic feg_sel_type decode(input logic [ADDR_W-1:0] addr);
        logic [11:0] a;
        a = addr[11:0];
        decode = FEG_SEL_NONE;
        if (addr[ADDR_W-1:8] == '0) begin
            case (a)
                FEG_OFF_CONTROL:    decode = FEG_SEL_CONTROL;
                FEG_OFF_MSG_DATA:   decode = FEG_SEL_MSG_DATA;
                FEG_OFF_MSG_ADDR:   decode = FEG_SEL_MSG_ADDR;
                FEG_OFF_IRQ_STATUS: decode = FEG_SEL_IRQ_STATUS;
                FEG_OFF_IRQ_MASK:   decode = FEG_SEL_IRQ_MASK;
                default:            decode = FEG_SEL_NONE;
            endcase
        end
    endfunction : decode

    // Merges a write into an old word under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    localparam logic [31:0] DATA_KEEP = EXT_DATA ? 32'hffff_ffff : 32'h0000_ffff;
    localparam logic [31:0] ADDR_KEEP = 32'hffff_fffc;

    // Register state.
    logic                 message_mask_bit;
    logic                 message_pending_bit;
    logic [31:0]          fault_event_message_data;
    logic [31:0]          message_address;
    logic [FEG_IRQ_W-1:0] irq_status;
    logic [FEG_IRQ_W-1:0] irq_mask;

    // Write channel state.
    logic                 aw_full;
    logic                 w_full;
    logic [ADDR_W-1:0]    aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 aw_take;
    logic                 w_take;
    logic                 wr_commit;
    feg_sel_type          wr_sel;

    assign aw_take   = s_axi_awvalid && s_axi_awready;
    assign w_take    = s_axi_wvalid && s_axi_wready;
    assign wr_commit = aw_full && w_full && !s_axi_bvalid;
    assign wr_sel    = decode(aw_addr);

    // Address and data are taken in either order and held until both are in.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= FEG_RST_WORD;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else if (ce) begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            aw_full       <= (aw_full || aw_take) && !wr_commit;
            w_full        <= (w_full || w_take) && !wr_commit;
            s_axi_awready <= !((aw_full || aw_take) && !wr_commit);
            s_axi_wready  <= !((w_full || w_take) && !wr_commit);
        end
    end

    // Write response; unmapped addresses answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= FEG_RESP_OKAY;
        end else if (ce) begin
            if (wr_commit) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == FEG_SEL_NONE) ? FEG_RESP_SLVERR : FEG_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one read in flight, data registered from the decoded word.
    logic        ar_take;
    logic [31:0] rd_word;
    feg_sel_type rd_sel;

    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_sel  = decode(s_axi_araddr);

    always_comb begin
        rd_word = FEG_RST_WORD;
        case (rd_sel)
            FEG_SEL_CONTROL: begin
                rd_word[FEG_BIT_MASK]    = message_mask_bit;
                rd_word[FEG_BIT_PENDING] = message_pending_bit;
            end
            FEG_SEL_MSG_DATA:   rd_word = fault_event_message_data;
            FEG_SEL_MSG_ADDR:   rd_word = message_address;
            FEG_SEL_IRQ_STATUS: rd_word[FEG_IRQ_W-1:0] = irq_status;
            FEG_SEL_IRQ_MASK:   rd_word[FEG_IRQ_W-1:0] = irq_mask;
            default:            rd_word = FEG_RST_WORD;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= FEG_RST_WORD;
            s_axi_rresp   <= FEG_RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= (rd_sel == FEG_SEL_NONE) ? FEG_RESP_SLVERR : FEG_RESP_OKAY;
            end else if (!s_axi_rvalid || s_axi_rready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b0;
            end
        end
    end

    // Control register: only the mask is writable, the pending bit is read-only.
    // mask reset set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            message_mask_bit <= FEG_RST_MASK;
        end else if (ce && wr_commit && wr_sel == FEG_SEL_CONTROL && w_strb[3]) begin
            message_mask_bit <= w_data[FEG_BIT_MASK];
        end
    end

    // Message data and address; narrow builds drop the upper data half.
    // low data held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_event_message_data <= FEG_RST_WORD;
            message_address          <= FEG_RST_WORD;
        end else if (ce && wr_commit) begin
            if (wr_sel == FEG_SEL_MSG_DATA) begin
                fault_event_message_data <= merge(fault_event_message_data, w_data, w_strb) & DATA_KEEP;
            end
            if (wr_sel == FEG_SEL_MSG_ADDR) begin
                message_address <= merge(message_address, w_data, w_strb) & ADDR_KEEP;
            end
        end
    end

    // Fault status flag tracking and interrupt condition detection.
    // primary flag OR
    logic primary_fault_flag;
    assign primary_fault_flag = |fault_present;

    // Positions in flags_now; bit 0 is the derived primary flag, the rest follow the status struct.
    localparam int unsigned FLAG_PRIMARY  = 0;
    localparam int unsigned FLAG_ADVANCED = 3;
    localparam int unsigned FLAG_QUEUE    = 4;
    localparam int unsigned FLAG_CPL_ERR  = 5;
    localparam int unsigned FLAG_CPL_TMO  = 6;

    logic [6:0] flags_now;
    logic [6:0] flags_q;
    logic [6:0] flags_rise;
    logic       cond;
    logic       logged_rise;

    assign flags_now  = {status_flags, primary_fault_flag};
    assign flags_rise = flags_now & ~flags_q;

    assign logged_rise = advanced_mode ? flags_rise[FLAG_ADVANCED] : flags_rise[FLAG_PRIMARY];

    assign cond = (flags_q == '0) && (logged_rise || flags_rise[FLAG_QUEUE] || flags_rise[FLAG_CPL_ERR]
                  || flags_rise[FLAG_CPL_TMO]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= '0;
        end else if (ce) begin
            flags_q <= flags_now;
        end
    end

    // The pending bit; a new condition wins over any clear in the same cycle.
    logic msg_take;
    logic sw_service;

    assign msg_take   = msg_valid && msg_ready;
    assign sw_service = message_pending_bit && !msg_valid && (flags_now == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            message_pending_bit <= FEG_RST_PENDING;
        end else if (ce) begin
            if (cond) begin
                message_pending_bit <= 1'b1;
            end else if (msg_take || sw_service) begin
                message_pending_bit <= 1'b0;
            end
        end
    end

    // Message issue. Once raised, valid is held until taken even if software masks
    // again, because a write on the interconnect cannot be withdrawn.
    // unmasked issue
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msg_valid <= 1'b0;
            msg_out   <= '0;
        end else if (ce) begin
            if (msg_take) begin
                msg_valid <= 1'b0;
            end else if (!msg_valid && message_pending_bit && !message_mask_bit && !sw_service) begin
                msg_valid               <= 1'b1;
                msg_out.message_address <= message_address;
                msg_out.message_data    <= fault_event_message_data;
            end
        end
    end

    // Local sticky interrupt status; hardware set wins over write-one-to-clear.
    logic [FEG_IRQ_W-1:0] ev_set;
    logic [FEG_IRQ_W-1:0] ev_clr;
    logic [FEG_IRQ_W-1:0] next_irq_status;
    logic [FEG_IRQ_W-1:0] next_irq_mask;

    // The output is built from the next status and the next mask, so a mask write acts at once.
    always_comb begin
        ev_set = '0;
        ev_set[FEG_EV_CONDITION]   = cond;
        ev_set[FEG_EV_SENT]        = msg_take;
        ev_set[FEG_EV_SW_SERVICED] = sw_service && !cond;
        ev_clr = '0;
        if (wr_commit && wr_sel == FEG_SEL_IRQ_STATUS && w_strb[0]) begin
            ev_clr = w_data[FEG_IRQ_W-1:0];
        end
        next_irq_status = (irq_status & ~ev_clr) | ev_set;
        next_irq_mask   = irq_mask;
        if (wr_commit && wr_sel == FEG_SEL_IRQ_MASK && w_strb[0]) begin
            next_irq_mask = w_data[FEG_IRQ_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= FEG_RST_IRQ;
            irq_mask   <= FEG_RST_IRQ;
            irq        <= 1'b0;
        end else if (ce) begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            irq        <= |(next_irq_status & next_irq_mask);
        end
    end

    // Checks on the behaviour above.
    AST_MASK_RESET: assert property (@(posedge aclk) !aresetn |=> message_mask_bit && !message_pending_bit)
        else $error("mask not set or pending not clear after reset");

    AST_NO_MSG_MASKED: assert property (@(posedge aclk) disable iff (!aresetn) $rose(msg_valid) |-> $past(!message_mask_bit))
        else $error("message raised while masked");

    AST_ISSUE_UNMASKED: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && message_pending_bit && !message_mask_bit && !msg_valid && !sw_service) |=> msg_valid)
        else $error("unmasked pending condition did not issue message");

    AST_COND_PENDS: assert property (@(posedge aclk) disable iff (!aresetn) (ce && cond) |=> message_pending_bit)
        else $error("condition did not set pending");

    AST_QUIET_BEFORE: assert property (@(posedge aclk) disable iff (!aresetn) cond |-> (flags_q == '0) && (flags_now != '0))
        else $error("condition taken while a flag was already set");

    AST_HELD_PENDING: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && message_pending_bit && message_mask_bit && flags_now != '0 && !msg_valid) |=> message_pending_bit)
        else $error("pending dropped while message held back");

    AST_SENT_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn) (ce && msg_take && !cond) |=> !message_pending_bit && !msg_valid)
        else $error("pending not cleared after message sent");

    AST_SW_SERVICE: assert property (@(posedge aclk) disable iff (!aresetn) (ce && sw_service && !cond) |=> !message_pending_bit && !msg_valid)
        else $error("software service did not clear pending quietly");

    AST_DATA_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn) msg_valid |-> (msg_out.message_data & ~DATA_KEEP) == '0)
        else $error("upper message data set in narrow build");

    AST_ADDR_ALIGN: assert property (@(posedge aclk) disable iff (!aresetn) msg_valid |-> msg_out.message_address[1:0] == 2'h0)
        else $error("message address not dword aligned");

    AST_PRIMARY_OR: assert property (@(posedge aclk) disable iff (!aresetn) ce |=> flags_q[0] == $past(|fault_present))
        else $error("primary flag is not the OR of fault bits");

    AST_MSG_STABLE: assert property (@(posedge aclk) disable iff (!aresetn)
        (msg_valid && !msg_ready) |=> msg_valid && $stable(msg_out))
        else $error("message changed or dropped before acceptance");

    AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn) ce |=> irq == |(irq_status & irq_mask))
        else $error("interrupt output disagrees with status and mask");

endmodule : feg_fault_event_gen

`default_nettype wire

/* File: bench/feg_msg_sink.sv */
`default_nettype none

module feg_msg_sink (
    input  wire logic aclk,      // System clock.
    input  wire logic aresetn,   // Synchronous reset, active low.
    input  wire logic msg_valid, // Message write offered.
    input  wire logic slow,      // High to stall three cycles before taking.
    output var  logic msg_ready  // Message write taken.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;

    // Take each offered write promptly or after a stall; ready drops after every take,
    // so a second message is never accepted in the same cycle as the first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msg_ready <= 1'b0;
            wait_cnt  <= 2'h0;
        end else if (msg_valid && !msg_ready) begin
            wait_cnt  <= wait_cnt + 2'h1;
            msg_ready <= slow ? (wait_cnt == 2'h3) : 1'b1;
        end else begin
            msg_ready <= 1'b0;
            wait_cnt  <= 2'h0;
        end
    end
endmodule : feg_msg_sink

`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import feg_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, advanced_mode = 1'b0, slow = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, d, a;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] fault_present = 8'h0;
    feg_status_type status_flags = '0;
    feg_msg_type msg_out;
    logic awready, wready, bvalid, arready, rvalid, msg_valid, msg_ready, irq;
    logic [1:0] bresp, rresp;
    logic [33:0] exp_rd[$];
    logic [63:0] exp_msg[$];
    int error_cnt = 0, tests_run = 0, msg_cnt = 0, seed = 25;

    always #5 aclk = ~aclk;

    feg_fault_event_gen DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fault_present(fault_present), .advanced_mode(advanced_mode), .status_flags(status_flags),
        .msg_out(msg_out), .msg_valid(msg_valid), .msg_ready(msg_ready), .irq(irq));

    feg_msg_sink SINK (.aclk(aclk), .aresetn(aresetn), .msg_valid(msg_valid), .slow(slow),
        .msg_ready(msg_ready));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic give_up();
        error_cnt++;
        end_of_test();
    endtask : give_up

    // Results are paired with the oldest note; an unexpected result meets an unknown and fails.
    always @(posedge aclk) begin
        if (rvalid && rready)
            chk({30'h0, rresp, rdata}, exp_rd.size() ? {30'h0, exp_rd.pop_front()} : 64'hx);
        if (msg_valid && msg_ready) begin
            msg_cnt++;
            chk(msg_out, exp_msg.size() ? exp_msg.pop_front() : 64'hx);
        end
    end

    // Address and data are offered together and each is released once taken.
    task automatic wr(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        if (n == 50) give_up();
        bready <= 1'b0;
        chk(bresp, er);
    endtask : wr

    task automatic rd(input logic [11:0] ad, input logic [33:0] ex);
        int n;
        exp_rd.push_back(ex);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        if (n == 50) give_up();
        rready <= 1'b0;
    endtask : rd

    // Raise one fault status source; kind 5 is an overflow, which never triggers alone.
    task automatic raise(input int kind);
        @(posedge aclk);
        advanced_mode <= (kind == 1);
        case (kind)
            0: fault_present <= 8'h1 << ($unsigned($random(seed)) % 8);
            1: status_flags.advanced_fault_flag <= 1'b1;
            2: status_flags.queue_error_flag <= 1'b1;
            3: status_flags.completion_error_flag <= 1'b1;
            4: status_flags.completion_timeout_flag <= 1'b1;
            default: status_flags.fault_overflow_flag <= 1'b1;
        endcase
        repeat (4) @(posedge aclk);
    endtask : raise

    task automatic clear_flags();
        @(posedge aclk);
        status_flags <= '0;
        fault_present <= 8'h0;
        repeat (4) @(posedge aclk);
    endtask : clear_flags

    task automatic wait_msg(input int cnt);
        int n;
        for (n = 0; n < 100 && msg_cnt != cnt; n++) @(posedge aclk);
        if (msg_cnt != cnt) give_up();
    endtask : wait_msg

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // Reset values, narrow data, aligned address and unmapped places.
        rd(FEG_OFF_CONTROL, {FEG_RESP_OKAY, 32'h8000_0000});
        rd(FEG_OFF_MSG_DATA, {FEG_RESP_OKAY, 32'h0});
        rd(12'h100, {FEG_RESP_SLVERR, 32'h0});
        wr(12'h100, 32'h1, FEG_RESP_SLVERR);
        wr(FEG_OFF_MSG_DATA, 32'hffff_1234, FEG_RESP_OKAY);
        rd(FEG_OFF_MSG_DATA, {FEG_RESP_OKAY, 32'h0000_1234});
        wr(FEG_OFF_MSG_ADDR, 32'habcd_ef03, FEG_RESP_OKAY);
        rd(FEG_OFF_MSG_ADDR, {FEG_RESP_OKAY, 32'habcd_ef00});
        // Masked condition stays pending and raises the local interrupt when enabled.
        raise(2);
        rd(FEG_OFF_CONTROL, {FEG_RESP_OKAY, 32'hc000_0000});
        chk(irq, 1'b0);
        wr(FEG_OFF_IRQ_MASK, 32'h1, FEG_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        wr(FEG_OFF_IRQ_STATUS, 32'h7, FEG_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        // Software clears the flags: pending drops with no message.
        clear_flags();
        rd(FEG_OFF_CONTROL, {FEG_RESP_OKAY, 32'h8000_0000});
        // Held message leaves once the mask opens, then pending clears.
        raise(3);
        exp_msg.push_back({32'habcd_ef00, 32'h0000_1234});
        wr(FEG_OFF_CONTROL, 32'h0, FEG_RESP_OKAY);
        wait_msg(1);
        rd(FEG_OFF_CONTROL, {FEG_RESP_OKAY, 32'h0});
        clear_flags();
        // Every trigger source in turn, with random payloads and a receiver that stalls for every second source.
        for (int k = 0; k < 5; k++) begin
            d = $random(seed);
            a = $random(seed);
            slow <= k[0];
            wr(FEG_OFF_MSG_DATA, d, FEG_RESP_OKAY);
            wr(FEG_OFF_MSG_ADDR, a, FEG_RESP_OKAY);
            exp_msg.push_back({a & 32'hffff_fffc, 16'h0, d[15:0]});
            raise(k);
            wait_msg(k + 2);
            clear_flags();
        end
        // A flag already set blocks a new condition.
        raise(5);
        raise(2);
        repeat (6) @(posedge aclk);
        chk(msg_cnt, 6);
        rd(FEG_OFF_CONTROL, {FEG_RESP_OKAY, 32'h0});
        clear_flags();
        chk(exp_msg.size() + exp_rd.size(), 0);
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
